// ---- verilog/fcr_config_regs.sv ----
// Configuration register bank of a serial flash: stored registers and working configuration
`timescale 1ns/1ps
module fcr_config_regs
  import fcr_pkg::*;
#(
  parameter int FEATURE_DIGIT = FEATURE_DIGIT_DEF
) (
  input wire logic CLK_IN,
  input wire logic RSTN_IN,
  input wire logic FACTORY_RSTN_IN,
  input wire logic SCLK_IN,
  input wire logic CS_N_IN,
  input wire logic DQ0_IN,
  output logic DQ1_OUT,
  output logic DQ1_OEN_OUT,
  output logic [3:0] DUMMY_CYCLES_OUT,
  output logic [2:0] XIP_MODE_OUT,
  output logic XIP_ACTIVE_OUT,
  output logic [2:0] DRIVE_CODE_OUT,
  output logic HOLD_RESET_EN_OUT,
  output fcr_proto_t PROTOCOL_OUT,
  output logic SEGMENT_LOWER_OUT,
  output logic ADDR_4BYTE_OUT,
  output logic EXT_ADDR_IGNORE_OUT,
  output logic [1:0] WRAP_MODE_OUT,
  output fcr_nv_t NV_CONFIG_OUT,
  output fcr_v_t V_CONFIG_OUT
);

  // Variants whose execute-in-place is hard-wired on
  localparam logic XIP_FORCED = (FEATURE_DIGIT == FEATURE_XIP_A) || (FEATURE_DIGIT == FEATURE_XIP_B);

  // ==========================================================
  // Block overview
  // The host reaches both registers only through the serial link, which runs on
  // its own clock and may stop between frames. All frame decoding lives in the
  // link module; this module owns the stored registers and the working setup.
  //
  // Crossing towards the core:
  // A finished write leaves its data in a link-side register and flips a toggle.
  // The toggle passes a synchroniser here and becomes a single core pulse.
  // The data word is not synchronised bit by bit; it stays unchanged until the
  // next write, which cannot finish sooner than a whole frame later, so it is
  // settled long before the pulse reads it.
  //
  // Crossing towards the link:
  // Every write and every boot flips the readback toggle; the factory strobe does not. The link picks
  // it up on its own clock during the opcode of the next frame and takes a
  // snapshot of both registers. A change that lands inside a running read frame
  // shows up only at the next load of the read word, which keeps one read word self-consistent.
  //
  // Reset:
  // The reset input stands for power-on. It loads defaults into the volatile register and the
  // working setup, then raises the boot flag for exactly one cycle. The stored
  // register is deliberately left alone; only the factory strobe writes all ones.
  // Simulation must therefore hold both low together at start, or the stored
  // register starts unknown.
  //
  // Working setup:
  // Boot copies every field of the stored register but the reserved bit into the working setup and
  // mirrors the boot image into the volatile register. A later stored write
  // changes nothing in the working setup until the next boot. A volatile write changes the
  // dummy count, the execute-in-place enable and the wrap mode in the same cycle
  // as the volatile register itself.
  //
  // Limitations:
  // There is no write-enable latch and no busy time; writes land as soon as the
  // last data bit is clocked in. Reserved start-up modes behave as disabled.

  // Write carrier from the link, already stable when its toggle lands
  fcr_wr_t wr;
  logic wr_tgl;
  logic wr_pulse;

  // Factory strobe synchroniser; stage 0 feeds stage 1 only
  logic [1:0] fac_sync_ff;
  logic [1:0] nxt_fac_sync;

  // Stored registers and readback republish toggle
  fcr_nv_t nv_ff;
  fcr_nv_t nxt_nv;
  fcr_v_t v_ff;
  fcr_v_t nxt_v;
  logic rb_tgl_ff;
  logic nxt_rb_tgl;

  // One-cycle boot flag raised by reset
  logic boot_ff;
  logic nxt_boot;

  // Working configuration seen by the rest of the device
  logic [3:0] dummy_ff;
  logic [3:0] nxt_dummy;
  logic [2:0] xip_mode_ff;
  logic [2:0] nxt_xip_mode;
  logic xip_act_ff;
  logic nxt_xip_act;
  logic [2:0] drive_ff;
  logic [2:0] nxt_drive;
  logic hold_ff;
  logic nxt_hold;
  fcr_proto_t proto_ff;
  fcr_proto_t nxt_proto;
  logic seg_ff;
  logic nxt_seg;
  logic addr4_ff;
  logic nxt_addr4;
  logic ign_ff;
  logic nxt_ign;
  logic [1:0] wrap_ff;
  logic [1:0] nxt_wrap;

  // Volatile write image with the reserved bit forced low
  fcr_v_t v_new;

  // ==========================================================
  // Link side and crossing of completed writes
  fcr_spi_link u_link (
    .sclk_in(SCLK_IN),
    .cs_n_in(CS_N_IN),
    .rstn_in(RSTN_IN),
    .dq0_in(DQ0_IN),
    .rb_nv_in(nv_ff),
    .rb_v_in(v_ff),
    .rb_tgl_in(rb_tgl_ff),
    .dq1_out(DQ1_OUT),
    .dq1_oen_out(DQ1_OEN_OUT),
    .wr_out(wr),
    .wr_tgl_out(wr_tgl)
  );

  fcr_toggle_sync u_wr_sync (
    .clk_in(CLK_IN),
    .rstn_in(RSTN_IN),
    .tgl_in(wr_tgl),
    .pulse_out(wr_pulse)
  );

  // ==========================================================
  // Stored registers and readback publication
  always_comb begin
    nxt_fac_sync = {fac_sync_ff[0], FACTORY_RSTN_IN};
    v_new = fcr_v_t'(wr.data[7:0]);
    v_new.rsvd = 1'b0;
    nxt_nv = nv_ff;
    nxt_v = v_ff;
    nxt_rb_tgl = rb_tgl_ff;
    nxt_boot = 1'b0;
    // Factory strobe works with or without reset
    if (!fac_sync_ff[1]) begin
      nxt_nv = fcr_nv_t'(NV_FACTORY);
    end
    if (boot_ff) begin
      // Volatile copy mirrors the boot image; readback is republished once
      nxt_v.dummy = nv_ff.dummy;
      nxt_v.xip_n = (fcr_norm_xip(nv_ff.xip_mode) == XIP_DISABLED);
      nxt_v.rsvd = 1'b0;
      nxt_v.wrap = WRAP_SEQ;
      nxt_rb_tgl = ~rb_tgl_ff;
    end else if (wr_pulse) begin
      if (wr.is_nv) begin
        nxt_nv = fcr_nv_t'(wr.data);
      end else begin
        nxt_v = v_new;
      end
      nxt_rb_tgl = ~rb_tgl_ff;
    end
  end

  // Synchroniser runs through reset so the strobe is seen during it
  always_ff @(posedge CLK_IN) begin
    fac_sync_ff <= nxt_fac_sync;
    if (!RSTN_IN) begin
      boot_ff <= 1'b1;
      rb_tgl_ff <= 1'b0;
      v_ff <= V_DEFAULT;
      // Nonvolatile content survives a reset; only the factory strobe erases it
      nv_ff <= nxt_nv;
    end else begin
      boot_ff <= nxt_boot;
      rb_tgl_ff <= nxt_rb_tgl;
      v_ff <= nxt_v;
      nv_ff <= nxt_nv;
    end
  end

  // ==========================================================
  // Working configuration: loaded at boot, dynamic fields follow volatile writes
  always_comb begin
    nxt_dummy = dummy_ff;
    nxt_xip_mode = xip_mode_ff;
    nxt_xip_act = xip_act_ff;
    nxt_drive = drive_ff;
    nxt_hold = hold_ff;
    nxt_proto = proto_ff;
    nxt_seg = seg_ff;
    nxt_addr4 = addr4_ff;
    nxt_wrap = wrap_ff;
    if (boot_ff) begin
      nxt_dummy = fcr_norm_dummy(nv_ff.dummy);
      nxt_xip_mode = fcr_norm_xip(nv_ff.xip_mode);
      nxt_xip_act = XIP_FORCED || (fcr_norm_xip(nv_ff.xip_mode) != XIP_DISABLED);
      nxt_drive = nv_ff.drive;
      nxt_hold = nv_ff.hold_en;
      // Protocol is fixed here only, so later nonvolatile writes wait for a boot
      if (!nv_ff.quad_n) begin
        nxt_proto = FCR_PROTO_QUAD;
      end else if (!nv_ff.dual_n) begin
        nxt_proto = FCR_PROTO_DUAL;
      end else begin
        nxt_proto = FCR_PROTO_EXT;
      end
      nxt_seg = nv_ff.seg_lower;
      nxt_addr4 = !nv_ff.addr3;
      nxt_wrap = WRAP_SEQ;
    end else if (wr_pulse && !wr.is_nv) begin
      nxt_dummy = fcr_norm_dummy(v_new.dummy);
      nxt_xip_act = XIP_FORCED || !v_new.xip_n;
      nxt_wrap = v_new.wrap;
    end
    // Ignore flag tracks the address width of the same cycle
    nxt_ign = nxt_addr4;
  end

  always_ff @(posedge CLK_IN) begin
    // Reset values match an erased stored register
    if (!RSTN_IN) begin
      dummy_ff <= DUMMY_DEFAULT;
      xip_mode_ff <= XIP_DISABLED;
      xip_act_ff <= XIP_FORCED;
      drive_ff <= NV_FACTORY[8:6];
      hold_ff <= 1'b1;
      proto_ff <= FCR_PROTO_EXT;
      seg_ff <= 1'b1;
      addr4_ff <= 1'b0;
      ign_ff <= 1'b0;
      wrap_ff <= WRAP_SEQ;
    end else begin
      dummy_ff <= nxt_dummy;
      xip_mode_ff <= nxt_xip_mode;
      xip_act_ff <= nxt_xip_act;
      drive_ff <= nxt_drive;
      hold_ff <= nxt_hold;
      proto_ff <= nxt_proto;
      seg_ff <= nxt_seg;
      addr4_ff <= nxt_addr4;
      ign_ff <= nxt_ign;
      wrap_ff <= nxt_wrap;
    end
  end

  // ==========================================================
  // Outputs, each straight from a flip-flop
  assign DUMMY_CYCLES_OUT = dummy_ff;
  assign XIP_MODE_OUT = xip_mode_ff;
  assign XIP_ACTIVE_OUT = xip_act_ff;
  assign DRIVE_CODE_OUT = drive_ff;
  assign HOLD_RESET_EN_OUT = hold_ff;
  assign PROTOCOL_OUT = proto_ff;
  assign SEGMENT_LOWER_OUT = seg_ff;
  assign ADDR_4BYTE_OUT = addr4_ff;
  assign EXT_ADDR_IGNORE_OUT = ign_ff;
  assign WRAP_MODE_OUT = wrap_ff;
  assign NV_CONFIG_OUT = nv_ff;
  assign V_CONFIG_OUT = v_ff;

endmodule

// ---- verilog/fcr_pkg.sv ----
// Shared constants, carriers and helpers of the flash configuration register bank
package fcr_pkg;

  // ==========================================================
  // Register commands on the serial link
  localparam logic [7:0] OP_RD_NV = 8'hB5;
  localparam logic [7:0] OP_WR_NV = 8'hB1;
  localparam logic [7:0] OP_RD_V = 8'h85;
  localparam logic [7:0] OP_WR_V = 8'h81;

  // ==========================================================
  // Link bit counts (rising edges numbered from 0 in a frame)
  localparam logic [4:0] CNT_OPCODE = 5'h08;
  localparam logic [4:0] CNT_V_LAST = 5'h0F;
  localparam logic [4:0] CNT_NV_LAST = 5'h17;
  localparam logic [4:0] CNT_SAT = 5'h18;
  localparam logic [3:0] TX_LAST = 4'hF;

  // ==========================================================
  // Values after reset and field codes
  localparam logic [15:0] NV_FACTORY = 16'hFFFF;
  localparam logic [3:0] DUMMY_DEFAULT = 4'hF;
  localparam logic [3:0] DUMMY_ALIAS = 4'h0;
  localparam logic [2:0] XIP_DISABLED = 3'h7;
  localparam logic [2:0] XIP_RSVD_A = 3'h5;
  localparam logic [2:0] XIP_RSVD_B = 3'h6;
  localparam logic [1:0] WRAP_SEQ = 2'h3;
  localparam logic [7:0] V_DEFAULT = 8'hFB;
  localparam int FEATURE_DIGIT_DEF = 1;
  localparam int FEATURE_XIP_A = 2;
  localparam int FEATURE_XIP_B = 4;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic [3:0] dummy;
    logic [2:0] xip_mode;
    logic [2:0] drive;
    logic rsvd;
    logic hold_en;
    logic quad_n;
    logic dual_n;
    logic seg_lower;
    logic addr3;
  } fcr_nv_t;

  typedef struct packed {
    logic [3:0] dummy;
    logic xip_n;
    logic rsvd;
    logic [1:0] wrap;
  } fcr_v_t;

  typedef struct packed {
    logic is_nv;
    logic [15:0] data;
  } fcr_wr_t;

  typedef enum logic [2:0] {
    FCR_PROTO_EXT = 3'b001,
    FCR_PROTO_DUAL = 3'b010,
    FCR_PROTO_QUAD = 3'b100
  } fcr_proto_t;

  // ==========================================================
  // Helpers
  // Both dummy codes 0000 and 1111 mean the default count
  function automatic logic [3:0] fcr_norm_dummy(input logic [3:0] code);
    fcr_norm_dummy = (code == DUMMY_ALIAS) ? DUMMY_DEFAULT : code;
  endfunction

  // Reserved start-up modes fall back to disabled
  function automatic logic [2:0] fcr_norm_xip(input logic [2:0] code);
    fcr_norm_xip = (code == XIP_RSVD_A || code == XIP_RSVD_B) ? XIP_DISABLED : code;
  endfunction

endpackage

// ---- verilog/fcr_toggle_sync.sv ----
// Toggle synchroniser that turns a foreign-domain toggle into a local one-cycle pulse
`timescale 1ns/1ps
module fcr_toggle_sync (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic tgl_in,
  output logic pulse_out
);

  logic [2:0] sync_ff;
  logic [2:0] nxt_sync;

  // ==========================================================
  // Shift chain; stage 0 is only read by stage 1
  always_comb begin
    nxt_sync = {sync_ff[1:0], tgl_in};
  end

  // Asynchronous clear because the link clock may not run during reset
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sync_ff <= 3'h0;
    end else begin
      sync_ff <= nxt_sync;
    end
  end

  assign pulse_out = sync_ff[2] ^ sync_ff[1];

endmodule

// ---- verilog/fcr_spi_link.sv ----
// Serial link front end: command capture, register write assembly, readback shifting
`timescale 1ns/1ps
module fcr_spi_link
  import fcr_pkg::*;
(
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic rstn_in,
  input wire logic dq0_in,
  input wire fcr_nv_t rb_nv_in,
  input wire fcr_v_t rb_v_in,
  input wire logic rb_tgl_in,
  output logic dq1_out,
  output logic dq1_oen_out,
  output fcr_wr_t wr_out,
  output logic wr_tgl_out
);

  logic [4:0] cnt_ff, nxt_cnt;
  logic [7:0] op_ff, nxt_op;
  logic [15:0] sh_ff, nxt_sh;
  fcr_wr_t wr_ff, nxt_wr;
  logic wr_tgl_ff, nxt_wr_tgl;
  fcr_nv_t snap_nv_ff, nxt_snap_nv;
  fcr_v_t snap_v_ff, nxt_snap_v;
  logic [15:0] tx_ff, nxt_tx;
  logic [3:0] txc_ff, nxt_txc;
  logic dq1_ff, nxt_dq1;
  logic oen_ff, nxt_oen;
  logic rb_pulse;
  logic [15:0] rd_word;

  fcr_toggle_sync u_rb_sync (
    .clk_in(sclk_in),
    .rstn_in(rstn_in),
    .tgl_in(rb_tgl_in),
    .pulse_out(rb_pulse)
  );

  // ==========================================================
  // Frame state: counter, opcode, data shift (cleared by chip select high)
  always_comb begin
    nxt_cnt = (cnt_ff == CNT_SAT) ? cnt_ff : cnt_ff + 5'h01;
    nxt_op = (cnt_ff < CNT_OPCODE) ? {op_ff[6:0], dq0_in} : op_ff;
    nxt_sh = (cnt_ff >= CNT_OPCODE) ? {sh_ff[14:0], dq0_in} : sh_ff;
  end

  always_ff @(posedge sclk_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      cnt_ff <= 5'h00;
      op_ff <= 8'h00;
      sh_ff <= 16'h0000;
    end else begin
      cnt_ff <= nxt_cnt;
      op_ff <= nxt_op;
      sh_ff <= nxt_sh;
    end
  end

  // ==========================================================
  // Persistent state: completed writes and readback snapshots
  // Write data is held until the next write, far longer than the core sync delay
  always_comb begin
    nxt_wr = wr_ff;
    nxt_wr_tgl = wr_tgl_ff;
    if (op_ff == OP_WR_V && cnt_ff == CNT_V_LAST) begin
      nxt_wr.is_nv = 1'b0;
      nxt_wr.data = {8'h00, sh_ff[6:0], dq0_in};
      nxt_wr_tgl = ~wr_tgl_ff;
    end else if (op_ff == OP_WR_NV && cnt_ff == CNT_NV_LAST) begin
      // Low byte arrives first
      nxt_wr.is_nv = 1'b1;
      nxt_wr.data = {sh_ff[6:0], dq0_in, sh_ff[14:7]};
      nxt_wr_tgl = ~wr_tgl_ff;
    end
    nxt_snap_nv = rb_pulse ? rb_nv_in : snap_nv_ff;
    nxt_snap_v = rb_pulse ? rb_v_in : snap_v_ff;
  end

  always_ff @(posedge sclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wr_ff <= '0;
      wr_tgl_ff <= 1'b0;
      snap_nv_ff <= NV_FACTORY;
      snap_v_ff <= V_DEFAULT;
    end else begin
      wr_ff <= nxt_wr;
      wr_tgl_ff <= nxt_wr_tgl;
      snap_nv_ff <= nxt_snap_nv;
      snap_v_ff <= nxt_snap_v;
    end
  end

  // ==========================================================
  // Readback on falling edges; the register repeats while the frame lasts
  always_comb begin
    rd_word = (op_ff == OP_RD_NV) ? {snap_nv_ff[7:0], snap_nv_ff[15:8]} : {snap_v_ff, snap_v_ff};
    nxt_tx = tx_ff;
    nxt_txc = txc_ff;
    nxt_dq1 = dq1_ff;
    nxt_oen = oen_ff;
    if (cnt_ff >= CNT_OPCODE && (op_ff == OP_RD_NV || op_ff == OP_RD_V)) begin
      nxt_oen = 1'b0;
      nxt_txc = txc_ff + 4'h1;
      if (oen_ff || txc_ff == TX_LAST) begin
        nxt_dq1 = rd_word[15];
        nxt_tx = {rd_word[14:0], 1'b0};
        nxt_txc = 4'h0;
      end else begin
        nxt_dq1 = tx_ff[15];
        nxt_tx = {tx_ff[14:0], 1'b0};
      end
    end
  end

  always_ff @(negedge sclk_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      tx_ff <= 16'h0000;
      txc_ff <= 4'h0;
      dq1_ff <= 1'b0;
      oen_ff <= 1'b1;
    end else begin
      tx_ff <= nxt_tx;
      txc_ff <= nxt_txc;
      dq1_ff <= nxt_dq1;
      oen_ff <= nxt_oen;
    end
  end

  assign dq1_out = dq1_ff;
  assign dq1_oen_out = oen_ff;
  assign wr_out = wr_ff;
  assign wr_tgl_out = wr_tgl_ff;

endmodule

// ---- verification/fcr_config_props.sv ----
// Concurrent checks on the outputs of the configuration register bank
`timescale 1ns/1ps
module fcr_config_props
  import fcr_pkg::*;
#(
  parameter int FEATURE_DIGIT = 1
) (
  input wire logic CLK_IN,
  input wire logic RSTN_IN,
  input wire logic FACTORY_RSTN_IN,
  input wire logic CS_N_IN,
  input wire logic DQ1_OEN_OUT,
  input wire logic [3:0] DUMMY_CYCLES_OUT,
  input wire logic [2:0] XIP_MODE_OUT,
  input wire logic XIP_ACTIVE_OUT,
  input wire logic HOLD_RESET_EN_OUT,
  input wire fcr_proto_t PROTOCOL_OUT,
  input wire logic SEGMENT_LOWER_OUT,
  input wire logic ADDR_4BYTE_OUT,
  input wire logic EXT_ADDR_IGNORE_OUT,
  input wire logic [1:0] WRAP_MODE_OUT,
  input wire fcr_nv_t NV_CONFIG_OUT,
  input wire fcr_v_t V_CONFIG_OUT
);
  // ==========================================================
  // Local decode, kept apart from the design helpers on purpose
  function automatic logic [3:0] exp_dummy(input logic [3:0] c);
    exp_dummy = (c == 4'h0) ? 4'hF : c;
  endfunction
  function automatic logic [2:0] exp_proto(input fcr_nv_t n);
    exp_proto = !n.quad_n ? 3'h4 : (!n.dual_n ? 3'h2 : 3'h1);
  endfunction
  function automatic logic [2:0] exp_xipm(input logic [2:0] m);
    exp_xipm = (m == 3'h5 || m == 3'h6) ? 3'h7 : m;
  endfunction
  // Forced variants keep execute-in-place on whatever is written
  localparam logic XIP_FORCED = (FEATURE_DIGIT == 2) || (FEATURE_DIGIT == 4);

  // ==========================================================
  // Assertions, all in the core clock domain
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RSTN_IN);

  AST_BOOT_PROTO: assert property ($rose(RSTN_IN) |-> ##1 PROTOCOL_OUT == exp_proto(NV_CONFIG_OUT))
    else $error("protocol after boot does not follow stored bits");
  AST_BOOT_FIELDS: assert property ($rose(RSTN_IN) |-> ##1 (HOLD_RESET_EN_OUT == NV_CONFIG_OUT.hold_en
    && SEGMENT_LOWER_OUT == NV_CONFIG_OUT.seg_lower && ADDR_4BYTE_OUT == !NV_CONFIG_OUT.addr3))
    else $error("boot fields do not follow stored bits");
  AST_BOOT_DUMMY: assert property ($rose(RSTN_IN) |-> ##1 DUMMY_CYCLES_OUT == exp_dummy(NV_CONFIG_OUT.dummy))
    else $error("boot dummy count wrong");
  AST_BOOT_XIPM: assert property ($rose(RSTN_IN) |-> ##1 XIP_MODE_OUT == exp_xipm(NV_CONFIG_OUT.xip_mode))
    else $error("boot execute-in-place mode wrong");
  AST_PROTO_HOLD: assert property ($past(RSTN_IN, 3) && $past(RSTN_IN, 2) && $past(RSTN_IN) |-> $stable(PROTOCOL_OUT))
    else $error("protocol changed without a boot");
  AST_V_APPLY: assert property ($changed(V_CONFIG_OUT) |-> ##1 (DUMMY_CYCLES_OUT == exp_dummy(V_CONFIG_OUT.dummy)
    && WRAP_MODE_OUT == V_CONFIG_OUT.wrap))
    else $error("volatile setting not applied");
  AST_V_XIP: assert property ($changed(V_CONFIG_OUT) |-> ##1 XIP_ACTIVE_OUT == (XIP_FORCED || !V_CONFIG_OUT.xip_n))
    else $error("execute-in-place enable wrong");
  AST_V_RSVD: assert property (V_CONFIG_OUT.rsvd == 1'b0)
    else $error("reserved volatile bit set");
  AST_EXT_IGNORE: assert property (EXT_ADDR_IGNORE_OUT == ADDR_4BYTE_OUT)
    else $error("extended address ignore mismatch");
  AST_FACTORY: assert property (!FACTORY_RSTN_IN [*4] |-> NV_CONFIG_OUT == 16'hFFFF)
    else $error("factory state not all ones");
  AST_OEN_IDLE: assert property (CS_N_IN |-> DQ1_OEN_OUT)
    else $error("data out enabled outside a frame");
endmodule

bind fcr_config_regs fcr_config_props #(.FEATURE_DIGIT(FEATURE_DIGIT)) i_props (
  .CLK_IN(CLK_IN), .RSTN_IN(RSTN_IN), .FACTORY_RSTN_IN(FACTORY_RSTN_IN), .CS_N_IN(CS_N_IN),
  .DQ1_OEN_OUT(DQ1_OEN_OUT), .DUMMY_CYCLES_OUT(DUMMY_CYCLES_OUT), .XIP_MODE_OUT(XIP_MODE_OUT),
  .XIP_ACTIVE_OUT(XIP_ACTIVE_OUT), .HOLD_RESET_EN_OUT(HOLD_RESET_EN_OUT), .PROTOCOL_OUT(PROTOCOL_OUT),
  .SEGMENT_LOWER_OUT(SEGMENT_LOWER_OUT), .ADDR_4BYTE_OUT(ADDR_4BYTE_OUT),
  .EXT_ADDR_IGNORE_OUT(EXT_ADDR_IGNORE_OUT), .WRAP_MODE_OUT(WRAP_MODE_OUT),
  .NV_CONFIG_OUT(NV_CONFIG_OUT), .V_CONFIG_OUT(V_CONFIG_OUT)
);

// ---- verification/fcr_host_model.sv ----
// Behavioural serial host that issues register command frames
`timescale 1ns/1ps
module fcr_host_model (
  output logic sclk_out,
  output logic cs_n_out,
  output logic dq0_out,
  input wire logic dq1_in,
  input wire logic dq1_oe_n_in
);
  // ==========================================================
  // Idle: link clock stands low, frame deselected
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    dq0_out = 1'b0;
  end

  // One frame of n edges; register commands or an unknown opcode, never a fast read, so no dummy count is relied on
  task automatic frame(input logic [7:0] op, input logic [15:0] d, input int n, output logic [15:0] rd);
    logic [23:0] sh;
    logic [15:0] rx;
    sh = {op, d[7:0], d[15:8]};
    rx = 16'h0000;
    #3 cs_n_out = 1'b0;
    for (int i = 0; i < n; i++) begin
      #37 dq0_out = sh[23 - i];
      #40 sclk_out = 1'b1;
      // A released data line reads inverted so it never passes for data
      if (i >= 8) rx = {rx[14:0], dq1_oe_n_in ? ~dq1_in : dq1_in};
      #3 sclk_out = 1'b0;
    end
    #37 cs_n_out = 1'b1;
    dq0_out = ~dq0_out;
    #120 rd = {rx[7:0], rx[15:8]};
  endtask
endmodule

// ---- verification/tb_top.sv ----
// Self-checking bench for the configuration register bank
`timescale 1ns/1ps
module tb_top
  import fcr_pkg::*;
;
  typedef struct packed {
    logic [7:0] wr;
    logic [7:0] v;
    logic [3:0] dummy;
    logic [1:0] wrap;
    logic xip;
  } fcr_row_t;
  logic clk = 1'b0, rst_n = 1'b0, fact_rst_n = 1'b0;
  logic sclk, cs_n, dq0, dq1, dq1_oe_n, xip_act, hold, seg, a4, ign;
  logic [3:0] dummy;
  logic [2:0] xip_mode, drive;
  logic [1:0] wrap;
  logic [15:0] rd;
  fcr_proto_t proto;
  fcr_nv_t nv;
  fcr_v_t v;
  int errors = 0, check_count = 0;
  // Volatile writes: wrap codes 0..3, dummy alias 0, reserved bit set
  fcr_row_t rows [4] = '{'{8'h5A, 8'h5A, 4'h5, 2'h2, 1'b0}, '{8'h07, 8'h03, 4'hF, 2'h3, 1'b1},
    '{8'hF1, 8'hF1, 4'hF, 2'h1, 1'b1}, '{8'h2C, 8'h28, 4'h2, 2'h0, 1'b0}};

  always #4 clk = ~clk;

  fcr_config_regs i_dut (.CLK_IN(clk), .RSTN_IN(rst_n), .FACTORY_RSTN_IN(fact_rst_n), .SCLK_IN(sclk),
    .CS_N_IN(cs_n), .DQ0_IN(dq0), .DQ1_OUT(dq1), .DQ1_OEN_OUT(dq1_oe_n), .DUMMY_CYCLES_OUT(dummy),
    .XIP_MODE_OUT(xip_mode), .XIP_ACTIVE_OUT(xip_act), .DRIVE_CODE_OUT(drive), .HOLD_RESET_EN_OUT(hold),
    .PROTOCOL_OUT(proto), .SEGMENT_LOWER_OUT(seg), .ADDR_4BYTE_OUT(a4), .EXT_ADDR_IGNORE_OUT(ign),
    .WRAP_MODE_OUT(wrap), .NV_CONFIG_OUT(nv), .V_CONFIG_OUT(v));
  fcr_host_model i_host (.sclk_out(sclk), .cs_n_out(cs_n), .dq0_out(dq0), .dq1_in(dq1), .dq1_oe_n_in(dq1_oe_n));

  // ==========================================================
  // Shared helpers
  task automatic check(input logic [19:0] seen, input logic [19:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask
  // Boot only: working outputs are rebuilt from the stored register
  task automatic reboot();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Watchdog so a hung run still ends in the report
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    $display("ERROR at %0t: run timed out", $time);
    stop_test();
  end

  // ==========================================================
  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    fact_rst_n <= 1'b1;
    reboot();
    check({dummy, xip_mode, xip_act, drive, hold, proto, seg, a4, ign, wrap},
      {4'hF, 3'h7, 1'h0, 3'h7, 1'h1, 3'h1, 1'h1, 1'h0, 1'h0, 2'h3}, "factory boot outputs");
    check(nv, 16'hFFFF, "factory stored value");
    check(v, 8'hFB, "volatile after boot");
    i_host.frame(OP_RD_NV, 16'h0000, 24, rd);
    check(rd, 16'hFFFF, "stored readback");
    $display("test reset done");
    foreach (rows[i]) begin
      i_host.frame(OP_WR_V, {8'h00, rows[i].wr}, 16, rd);
      check(v, rows[i].v, "volatile store");
      check(dummy, rows[i].dummy, "working dummy");
      check(wrap, rows[i].wrap, "working wrap");
      check(xip_act, rows[i].xip, "execute-in-place");
      i_host.frame(OP_RD_V, 16'h0000, 24, rd);
      check(rd, {rows[i].v, rows[i].v}, "volatile readback");
    end
    $display("test volatile rows done");
    // Stored write must not touch the working setup before a boot
    i_host.frame(OP_WR_NV, 16'h3860, 24, rd);
    check(nv, 16'h3860, "stored write");
    check(proto, FCR_PROTO_EXT, "protocol before boot");
    i_host.frame(OP_RD_NV, 16'h0000, 24, rd);
    check(rd, 16'h3860, "stored readback");
    reboot();
    check({dummy, xip_mode, xip_act, drive, hold, proto, seg, a4, ign, wrap},
      {4'h3, 3'h4, 1'h1, 3'h1, 1'h0, 3'h4, 1'h0, 1'h1, 1'h1, 2'h3}, "boot quad 4-byte");
    check(v, 8'h33, "volatile copy of boot");
    $display("test stored boot done");
    // Cut-short write and unknown command leave the register alone
    i_host.frame(OP_WR_NV, 16'h1234, 20, rd);
    i_host.frame(8'hA5, 16'h5678, 24, rd);
    check(nv, 16'h3860, "refused frames");
    $display("test refused frames done");
    i_host.frame(OP_WR_NV, 16'h0AFB, 24, rd);
    reboot();
    check({dummy, xip_mode, xip_act, drive, hold, proto, seg, a4, ign, wrap},
      {4'hF, 3'h7, 1'h0, 3'h3, 1'h1, 3'h2, 1'h1, 1'h0, 1'h0, 2'h3}, "boot dual reserved");
    $display("test dual boot done");
    @(posedge clk);
    fact_rst_n <= 1'b0;
    repeat (5) @(posedge clk);
    fact_rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    check(nv, 16'hFFFF, "factory restore");
    check(proto, FCR_PROTO_DUAL, "protocol kept until boot");
    $display("test factory restore done");
    stop_test();
  end
endmodule
